// *** hdl/serial_flash_pkg.sv ***
package serial_flash_pkg;

    // command opcodes, values arbitrary for this core
    localparam logic [7:0] OP_BUF_WR = 8'h21;
    localparam logic [7:0] OP_BUF_RD = 8'h22;
    localparam logic [7:0] OP_PROG = 8'h31;
    localparam logic [7:0] OP_ERASE = 8'h32;
    localparam logic [7:0] OP_CMP = 8'h33;
    localparam logic [7:0] OP_XFER = 8'h34;
    localparam logic [7:0] OP_MAP_WR = 8'h41;
    localparam logic [7:0] OP_PROT_EN = 8'h42;
    localparam logic [7:0] OP_LOCK = 8'h43;

    // kind of self-timed operation handed to the array core
    typedef enum logic [1:0] {K_PROG, K_ERASE, K_CMP, K_XFER} kind_e;

    // serial framing
    localparam int BYTE_W = 8;
    localparam logic [2:0] BIT_FIRST = 3'h0;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [2:0] BIT_STEP = 3'h1;

    // address byte layout: buffer select on top, index below
    localparam int BUF_SEL_BIT = 7;
    localparam int IDX_W = 7;
    localparam int BUF_DEPTH = 2 ** IDX_W;
    localparam logic [IDX_W-1:0] IDX_STEP = 7'h01;

    // default sector count, at most one data byte wide
    localparam int NSECT_DEF = 8;

    // self-timed operation length: a least time, rounded up
    localparam int CLK_PERIOD_NS = 10;
    localparam int BUSY_TIME_NS = 2000;
    localparam int BUSY_CYCLES_DEF =
        (BUSY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // pin synchroniser lanes
    localparam int SYNC_W = 5;
    localparam int PIN_CS = 0;
    localparam int PIN_SCK = 1;
    localparam int PIN_SI = 2;
    localparam int PIN_WP = 3;
    localparam int PIN_RST = 4;
    localparam logic [SYNC_W-1:0] PINS_IDLE = 5'h19;

endpackage

// *** hdl/pin_sync.sv ***
`timescale 1ns/1ps
`default_nettype none

// two-stage synchroniser for asynchronous pin levels
module pin_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_q;

    ////////////////////////////////////////////////////////////////////
    // first stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (!nrst) begin
            meta_q <= INIT;
            q <= INIT;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end

endmodule // pin_sync

`default_nettype wire

// *** hdl/serial_flash_ctrl.sv ***
// Function
// - sample serial input on serial clock rise
// - opcodes, addresses, write data share input line
// - shift serial output on serial clock fall
// - write protect shields mapped sectors always
// - hardware protect independent of software protect
// - protection map frozen while write protect low
// - program or erase discarded under write protect
// - discarded command idles after chip select rises
// - protect enable and lockdown accepted under protect
// - reset pin aborts operation, forces idle
// - held in reset while reset pin low
// - commands accepted again after reset pin high
// - internal power-on reset needs no pin sequencing
// - ready/busy open drain, pulled low while busy
// - busy during program, erase, compare, transfer
// - busy blocks array and buffer in use
// - other buffer still served while busy
// - chip select fall starts, rise ends frame
// - deselect mid-operation keeps operation running
// - eight-bit opcode first, most significant bit first
`timescale 1ns/1ps
`default_nettype none

module serial_flash_ctrl #(
    parameter int NSECT = serial_flash_pkg::NSECT_DEF,
    parameter int BUSY_CYCLES = serial_flash_pkg::BUSY_CYCLES_DEF
) (
    input wire logic CLOCK,
    input wire logic NRST,
    input wire logic CS_N,
    input wire logic SCK,
    input wire logic SI,
    input wire logic WP_N,
    input wire logic RESET_N,
    output logic SO,
    output logic SO_OE,
    output logic RDY_BUSY_O,
    output logic RDY_BUSY_OE,
    output logic ARRAY_START,
    output serial_flash_pkg::kind_e ARRAY_KIND,
    output logic [$clog2(NSECT)-1:0] ARRAY_SECTOR,
    output logic ARRAY_BUF,
    output logic [NSECT-1:0] PROT_MAP,
    output logic PROT_EN,
    output logic [NSECT-1:0] LOCK_MAP
);

    localparam int SW = $clog2(NSECT);
    localparam int TW = $clog2(BUSY_CYCLES + 1);
    localparam logic [TW-1:0] TIMER_LOAD = TW'(BUSY_CYCLES);
    localparam logic [TW-1:0] TIMER_LAST = TW'(1);
    localparam logic [TW-1:0] TIMER_STEP = TW'(1);
    localparam int IW = serial_flash_pkg::IDX_W;
    localparam int BW = serial_flash_pkg::BYTE_W;

    typedef enum logic [2:0] {
        ST_IDLE, ST_OPCODE, ST_ADDR, ST_DATA, ST_IGNORE
    } state_e;

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [serial_flash_pkg::SYNC_W-1:0] pins_s;
    logic cs_n_s, sck_s, si_s, wp_n_s, rst_pin_s;

    // power-on reset (NRST) owns all but the buffer storage, pins need no order
    pin_sync #(
        .W(serial_flash_pkg::SYNC_W),
        .INIT(serial_flash_pkg::PINS_IDLE)
    ) u_sync (
        .clk(CLOCK),
        .nrst(NRST),
        .d({RESET_N, WP_N, SI, SCK, CS_N}),
        .q(pins_s)
    );

    assign cs_n_s = pins_s[serial_flash_pkg::PIN_CS];
    assign sck_s = pins_s[serial_flash_pkg::PIN_SCK];
    assign si_s = pins_s[serial_flash_pkg::PIN_SI];
    assign wp_n_s = pins_s[serial_flash_pkg::PIN_WP];
    assign rst_pin_s = pins_s[serial_flash_pkg::PIN_RST];

    ////////////////////////////////////////////////////////////////////
    // state
    state_e state_q, state_d;
    logic [2:0] bit_q, bit_d;
    logic [BW-1:0] rx_q, rx_d, op_q, op_d, tx_q, tx_d;
    logic [IW-1:0] ptr_q, ptr_d;
    logic sel_q, sel_d, so_q, so_d, so_oe_q, so_oe_d;
    logic sck_prev_q, cs_prev_q;
    logic [NSECT-1:0] map_q, map_d, lock_q, lock_d;
    logic prot_en_q, prot_en_d;
    logic busy_q, busy_d, bbuf_q, bbuf_d, buses_q, buses_d;
    logic [TW-1:0] timer_q, timer_d;
    logic start_q, start_d, abuf_q, abuf_d, rdy_oe_q;
    serial_flash_pkg::kind_e kind_q, kind_d;
    logic [SW-1:0] sector_q, sector_d;
    logic [BW-1:0] mem_q [0:1][0:serial_flash_pkg::BUF_DEPTH-1];
    logic mem_we;

    // edge detection on synchronised levels only
    logic sck_rise, sck_fall, cs_fall;
    logic [BW-1:0] byte_in, rd_word;
    logic [SW-1:0] sec;
    logic pe_op, arr_op, buf_op, prot_hit, buf_clash, rd_sel;
    logic [IW-1:0] rd_idx;

    assign sck_rise = sck_s && !sck_prev_q;
    assign sck_fall = !sck_s && sck_prev_q;
    assign cs_fall = !cs_n_s && cs_prev_q;
    // msb first: each new bit enters at the bottom
    assign byte_in = {rx_q[BW-2:0], si_s};
    assign sec = byte_in[SW-1:0];
    assign pe_op = (op_q == serial_flash_pkg::OP_PROG) ||
        (op_q == serial_flash_pkg::OP_ERASE);
    assign arr_op = pe_op || (op_q == serial_flash_pkg::OP_CMP) ||
        (op_q == serial_flash_pkg::OP_XFER);
    assign buf_op = (op_q == serial_flash_pkg::OP_BUF_WR) ||
        (op_q == serial_flash_pkg::OP_BUF_RD);
    // lockdown always wins; map bites with either protect path
    assign prot_hit = lock_q[sec] ||
        (map_q[sec] && (prot_en_q || !wp_n_s));
    // only the buffer tied up by the running operation is refused
    assign buf_clash = busy_q && buses_q &&
        (bbuf_q == byte_in[serial_flash_pkg::BUF_SEL_BIT]);
    // read index comes from the address byte on its last bit
    assign rd_sel = (state_q == ST_ADDR) ?
        byte_in[serial_flash_pkg::BUF_SEL_BIT] : sel_q;
    assign rd_idx = (state_q == ST_ADDR) ? byte_in[IW-1:0] : ptr_q;
    assign rd_word = mem_q[rd_sel][rd_idx];

    ////////////////////////////////////////////////////////////////////
    // next state: framing, command decode, protection, busy timer
    always_comb begin
        state_d = state_q;
        bit_d = bit_q;
        rx_d = rx_q;
        op_d = op_q;
        ptr_d = ptr_q;
        sel_d = sel_q;
        tx_d = tx_q;
        so_d = so_q;
        map_d = map_q;
        lock_d = lock_q;
        prot_en_d = prot_en_q;
        busy_d = busy_q;
        timer_d = timer_q;
        bbuf_d = bbuf_q;
        buses_d = buses_q;
        start_d = 1'b0;
        kind_d = kind_q;
        sector_d = sector_q;
        abuf_d = abuf_q;
        mem_we = 1'b0;

        // self-timed countdown runs regardless of chip select
        if (busy_q) begin
            if (timer_q == TIMER_LAST) begin
                busy_d = 1'b0;
            end else begin
                timer_d = timer_q - TIMER_STEP;
            end
        end

        if (cs_n_s) begin
            state_d = ST_IDLE;
        end else if (cs_fall && state_q == ST_IDLE) begin
            state_d = ST_OPCODE;
            bit_d = serial_flash_pkg::BIT_FIRST;
        end else if (sck_rise && state_q != ST_IDLE) begin
            // every inbound bit arrives on the one input line
            rx_d = byte_in;
            bit_d = bit_q + serial_flash_pkg::BIT_STEP;
            if (bit_q == serial_flash_pkg::BIT_LAST) begin
                case (state_q)
                    ST_OPCODE: begin
                        op_d = byte_in;
                        if (byte_in == serial_flash_pkg::OP_PROT_EN) begin
                            prot_en_d = 1'b1;
                            state_d = ST_IGNORE;
                        end else if (!wp_n_s && (
                            byte_in == serial_flash_pkg::OP_PROG ||
                            byte_in == serial_flash_pkg::OP_ERASE ||
                            byte_in == serial_flash_pkg::OP_MAP_WR)) begin
                            state_d = ST_IGNORE;
                        end else begin
                            state_d = ST_ADDR;
                        end
                    end
                    ST_ADDR: begin
                        ptr_d = byte_in[IW-1:0];
                        sel_d = byte_in[serial_flash_pkg::BUF_SEL_BIT];
                        state_d = ST_IGNORE;
                        if (arr_op) begin
                            // array is off limits while busy
                            if (!busy_q && !(pe_op &&
                                (prot_hit || !wp_n_s))) begin
                                start_d = 1'b1;
                                busy_d = 1'b1;
                                timer_d = TIMER_LOAD;
                                sector_d = sec;
                                abuf_d = sel_d;
                                bbuf_d = sel_d;
                                buses_d = (op_q !=
                                    serial_flash_pkg::OP_ERASE);
                                if (op_q == serial_flash_pkg::OP_PROG) begin
                                    kind_d = serial_flash_pkg::K_PROG;
                                end else if (op_q ==
                                    serial_flash_pkg::OP_ERASE) begin
                                    kind_d = serial_flash_pkg::K_ERASE;
                                end else if (op_q ==
                                    serial_flash_pkg::OP_CMP) begin
                                    kind_d = serial_flash_pkg::K_CMP;
                                end else begin
                                    kind_d = serial_flash_pkg::K_XFER;
                                end
                            end
                        end else if (op_q == serial_flash_pkg::OP_LOCK) begin
                            lock_d[sec] = 1'b1;
                        end else if (op_q ==
                            serial_flash_pkg::OP_MAP_WR) begin
                            state_d = ST_DATA;
                        end else if (buf_op && !buf_clash) begin
                            state_d = ST_DATA;
                            if (op_q == serial_flash_pkg::OP_BUF_RD) begin
                                tx_d = rd_word;
                                ptr_d = byte_in[IW-1:0] +
                                    serial_flash_pkg::IDX_STEP;
                            end
                        end
                    end
                    ST_DATA: begin
                        if (op_q == serial_flash_pkg::OP_MAP_WR) begin
                            // map only changes with write protect high
                            if (wp_n_s) begin
                                map_d = byte_in[NSECT-1:0];
                            end
                            state_d = ST_IGNORE;
                        end else if (op_q ==
                            serial_flash_pkg::OP_BUF_WR) begin
                            mem_we = 1'b1;
                            ptr_d = ptr_q + serial_flash_pkg::IDX_STEP;
                        end else begin
                            tx_d = rd_word;
                            ptr_d = ptr_q + serial_flash_pkg::IDX_STEP;
                        end
                    end
                    default: begin
                        state_d = state_q;
                    end
                endcase
            end
        end else if (sck_fall && state_q == ST_DATA &&
            op_q == serial_flash_pkg::OP_BUF_RD) begin
            so_d = tx_q[BW-1];
            tx_d = {tx_q[BW-2:0], 1'b0};
        end

        // reset pin aborts and holds everything idle
        if (!rst_pin_s) begin
            state_d = ST_IDLE;
            busy_d = 1'b0;
            timer_d = '0;
            start_d = 1'b0;
            mem_we = 1'b0;
        end
    end

    // output drives follow the settled next state
    assign so_oe_d = (state_d != ST_IDLE);

    ////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            state_q <= ST_IDLE;
            bit_q <= serial_flash_pkg::BIT_FIRST;
            rx_q <= '0;
            op_q <= '0;
            ptr_q <= '0;
            sel_q <= 1'b0;
            tx_q <= '0;
            so_q <= 1'b0;
            so_oe_q <= 1'b0;
            sck_prev_q <= 1'b0;
            cs_prev_q <= 1'b1;
            map_q <= '0;
            lock_q <= '0;
            prot_en_q <= 1'b0;
            busy_q <= 1'b0;
            timer_q <= '0;
            bbuf_q <= 1'b0;
            buses_q <= 1'b0;
            start_q <= 1'b0;
            kind_q <= serial_flash_pkg::K_PROG;
            sector_q <= '0;
            abuf_q <= 1'b0;
            rdy_oe_q <= 1'b0;
        end else begin
            state_q <= state_d;
            bit_q <= bit_d;
            rx_q <= rx_d;
            op_q <= op_d;
            ptr_q <= ptr_d;
            sel_q <= sel_d;
            tx_q <= tx_d;
            so_q <= so_d;
            so_oe_q <= so_oe_d;
            sck_prev_q <= sck_s;
            cs_prev_q <= cs_n_s;
            map_q <= map_d;
            lock_q <= lock_d;
            prot_en_q <= prot_en_d;
            busy_q <= busy_d;
            timer_q <= timer_d;
            bbuf_q <= bbuf_d;
            buses_q <= buses_d;
            start_q <= start_d;
            kind_q <= kind_d;
            sector_q <= sector_d;
            abuf_q <= abuf_d;
            rdy_oe_q <= busy_d;
        end
    end

    // buffer storage, no reset: contents are undefined at power-up
    always_ff @(posedge CLOCK) begin
        if (mem_we) begin
            mem_q[sel_q][ptr_q] <= byte_in;
        end
    end

    // open drain: level is always low, only the enable moves
    assign RDY_BUSY_O = 1'b0 & rdy_oe_q;
    assign RDY_BUSY_OE = rdy_oe_q;
    assign SO = so_q;
    assign SO_OE = so_oe_q;
    assign ARRAY_START = start_q;
    assign ARRAY_KIND = kind_q;
    assign ARRAY_SECTOR = sector_q;
    assign ARRAY_BUF = abuf_q;
    assign PROT_MAP = map_q;
    assign PROT_EN = prot_en_q;
    assign LOCK_MAP = lock_q;

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!NRST);

    logic last_bit;
    assign last_bit = sck_rise && !cs_n_s &&
        bit_q == serial_flash_pkg::BIT_LAST;

    property p_rx_rise;
        sck_rise && !cs_n_s && state_q != ST_IDLE && rst_pin_s
        |=> rx_q[0] == $past(si_s);
    endproperty
    a_rx_rise: assert property (p_rx_rise) else $error("bit not sampled");

    property p_so_fall;
        sck_fall && !cs_n_s && rst_pin_s && state_q == ST_DATA &&
        op_q == serial_flash_pkg::OP_BUF_RD
        |=> SO == $past(tx_q[BW-1]);
    endproperty
    a_so_fall: assert property (p_so_fall) else $error("so not shifted");

    property p_wp_discard;
        last_bit && !wp_n_s && (state_q == ST_OPCODE || pe_op)
        && (byte_in == serial_flash_pkg::OP_PROG ||
        byte_in == serial_flash_pkg::OP_ERASE || state_q == ST_ADDR)
        |=> !ARRAY_START ##1 !ARRAY_START;
    endproperty
    a_wp_discard: assert property (p_wp_discard) else $error("pe under wp");

    property p_map_frozen;
        !wp_n_s |=> $stable(map_q);
    endproperty
    a_map_frozen: assert property (p_map_frozen) else $error("map changed");

    property p_lock_wp;
        last_bit && rst_pin_s && state_q == ST_ADDR &&
        op_q == serial_flash_pkg::OP_LOCK |=> lock_q[$past(sec)];
    endproperty
    a_lock_wp: assert property (p_lock_wp) else $error("lock refused");

    property p_reset_pin;
        !rst_pin_s |=> state_q == ST_IDLE && !RDY_BUSY_OE && !SO_OE;
    endproperty
    a_reset_pin: assert property (p_reset_pin) else $error("reset ignored");

    property p_start_busy;
        ARRAY_START |-> RDY_BUSY_OE && !RDY_BUSY_O ##1 RDY_BUSY_OE [*7];
    endproperty
    a_start_busy: assert property (p_start_busy) else $error("busy short");

    property p_busy_blocks;
        busy_q |=> !ARRAY_START;
    endproperty
    a_busy_blocks: assert property (p_busy_blocks) else $error("array reused");

    property p_cs_idle;
        cs_n_s |=> state_q == ST_IDLE && !SO_OE;
    endproperty
    a_cs_idle: assert property (p_cs_idle) else $error("frame not ended");

    c_start: cover property (ARRAY_START);
    c_read: cover property (sck_fall && SO_OE && op_q ==
        serial_flash_pkg::OP_BUF_RD);
    c_wp_drop: cover property (last_bit && !wp_n_s &&
        state_q == ST_OPCODE && byte_in == serial_flash_pkg::OP_PROG);
    c_deselect_busy: cover property (cs_n_s && busy_q);

endmodule // serial_flash_ctrl

`default_nettype wire

// *** bench/flash_host.sv ***
`timescale 1ns/1ps
`default_nettype none

// host side of the link; clock idles low between frames
module flash_host (
    output logic cs_n,
    output logic sck,
    output logic si,
    input wire logic so
);
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
    end

    // chip select fall opens a frame, setup gap before first rise
    task automatic open_frame();
        cs_n = 1'b0;
        #100;
    endtask

    // rise ends the frame; idle data flips so no stale bit looks valid
    task automatic close_frame();
        #100;
        cs_n = 1'b1;
        si = ~si;
        #300;
    endtask

    // one byte each way, msb first, all inbound on the one line
    task automatic xfer(input logic [7:0] b, output logic [7:0] r);
        for (int i = 7; i >= 0; i--) begin
            si = b[i];
            #62.5;
            sck = 1'b1;
            r[i] = so;
            #62.5;
            sck = 1'b0;
        end
        si = ~b[0];
    endtask
endmodule // flash_host

`default_nettype wire

// *** bench/serial_flash_ctrl_test.sv ***
`timescale 1ns/1ps
`default_nettype none

module serial_flash_ctrl_test;
    // long enough busy to run three frames inside it
    localparam int BUSY = 1500;
    logic clock, nrst, wp_n, reset_n;
    wire cs_n, sck, si;
    logic so, so_oe, rb_o, rb_oe, start, abuf, pen;
    serial_flash_pkg::kind_e kind;
    logic [2:0] sect;
    logic [7:0] pmap, lmap, r;
    int miscompares, n_tests, starts;

    serial_flash_ctrl #(.NSECT(8), .BUSY_CYCLES(BUSY)) uut (
        .CLOCK(clock), .NRST(nrst), .CS_N(cs_n), .SCK(sck), .SI(si),
        .WP_N(wp_n), .RESET_N(reset_n), .SO(so), .SO_OE(so_oe),
        .RDY_BUSY_O(rb_o), .RDY_BUSY_OE(rb_oe), .ARRAY_START(start),
        .ARRAY_KIND(kind), .ARRAY_SECTOR(sect), .ARRAY_BUF(abuf),
        .PROT_MAP(pmap), .PROT_EN(pen), .LOCK_MAP(lmap)
    );
    flash_host host (.cs_n(cs_n), .sck(sck), .si(si), .so(so));

    always #5 clock = ~clock;

    // count started operations; one-cycle pulse is seen here
    always @(posedge clock) begin
        if (start === 1'b1) starts++;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t %h %h", $time, got, exp);
        end
    endtask

    task automatic end_sim();
        if (miscompares == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic frame(input logic [7:0] op, input logic [7:0] a);
        host.open_frame();
        host.xfer(op, r);
        host.xfer(a, r);
        host.close_frame();
    endtask

    // map write carries one data byte after the address byte
    task automatic map_wr(input logic [7:0] d);
        host.open_frame();
        host.xfer(8'h41, r);
        host.xfer(8'h00, r);
        host.xfer(d, r);
        host.close_frame();
    endtask

    // op with a start expected or not; start count checked after deselect
    task automatic op_chk(input logic [7:0] op, a, input int n_exp);
        int s0;
        s0 = starts;
        frame(op, a);
        chk(8'(starts - s0), 8'(n_exp));
    endtask

    // bounded wait for the pin to be released
    task automatic wait_ready();
        for (int n = 0; n < 2 * BUSY && rb_oe !== 1'b0; n++) @(posedge clock);
        chk({7'h00, rb_oe}, 8'h00);
    endtask

    task automatic wr_buf(input logic [7:0] a, d0, d1);
        host.open_frame();
        host.xfer(8'h21, r);
        host.xfer(a, r);
        host.xfer(d0, r);
        host.xfer(d1, r);
        chk({7'h00, so_oe}, 8'h01);
        host.close_frame();
    endtask

    task automatic rd_buf(input logic [7:0] a, e0, e1);
        host.open_frame();
        host.xfer(8'h22, r);
        host.xfer(a, r);
        host.xfer(8'h00, r);
        chk(r, e0);
        host.xfer(8'h00, r);
        chk(r, e1);
        host.close_frame();
    endtask

    ////////////////////////////////////////////////////////////////////////
    // every self-timed kind starts, pulls busy, survives deselect
    task automatic t_kinds();
        logic [7:0] ops [4] = '{8'h31, 8'h32, 8'h33, 8'h34};
        for (int i = 0; i < 4; i++) begin
            op_chk(ops[i], 8'h80 | 8'(i), 1);
            chk({6'h00, kind}, 8'(i));
            chk({5'h00, sect}, 8'(i));
            chk({7'h00, rb_oe}, 8'h01);
            chk({7'h00, rb_o}, 8'h00);
            wait_ready();
        end
    endtask

    // while buffer 0 is busy, buffer 1 still works, array refused
    task automatic t_other_buf();
        op_chk(8'h31, 8'h00, 1);
        chk({7'h00, abuf}, 8'h00);
        op_chk(8'h32, 8'h01, 0);
        wr_buf(8'h90, 8'hA5, 8'h3C);
        rd_buf(8'h90, 8'hA5, 8'h3C);
        chk({7'h00, rb_oe}, 8'h01);
        wait_ready();
    endtask

    task automatic t_protect();
        int s0;
        map_wr(8'h08);
        chk(pmap, 8'h08);
        @(posedge clock) wp_n <= 1'b0;
        repeat (4) @(posedge clock);
        map_wr(8'hFF);
        chk(pmap, 8'h08);
        op_chk(8'h31, 8'h01, 0);
        op_chk(8'h32, 8'h03, 0);
        chk({7'h00, rb_oe}, 8'h00);
        s0 = starts;
        host.open_frame();
        host.xfer(8'h42, r);
        host.close_frame();
        chk({7'h00, pen}, 8'h01);
        chk(8'(starts - s0), 8'h00);
        frame(8'h43, 8'h05);
        chk(lmap, 8'h20);
        @(posedge clock) wp_n <= 1'b1;
        repeat (4) @(posedge clock);
        op_chk(8'h31, 8'h03, 0);
        op_chk(8'h31, 8'h05, 0);
        op_chk(8'h31, 8'h04, 1);
        wait_ready();
    endtask

    task automatic t_pin_reset();
        op_chk(8'h31, 8'h84, 1);
        @(posedge clock) reset_n <= 1'b0;
        repeat (5) @(posedge clock);
        chk({7'h00, rb_oe}, 8'h00);
        op_chk(8'h31, 8'h84, 0);
        @(posedge clock) reset_n <= 1'b1;
        repeat (5) @(posedge clock);
        op_chk(8'h31, 8'h84, 1);
        wait_ready();
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence; power-on reset only, no pin sequencing needed
    initial begin
        clock = 1'b0;
        nrst = 1'b0;
        wp_n = 1'b1;
        reset_n = 1'b1;
        repeat (8) @(posedge clock);
        nrst <= 1'b1;
        repeat (4) @(posedge clock);
        chk({6'h00, so_oe, rb_oe}, 8'h00);
        t_kinds();
        t_other_buf();
        t_protect();
        t_pin_reset();
        end_sim();
    end

    // hang guard, well past the expected run
    initial begin
        #400us;
        miscompares++;
        end_sim();
    end
endmodule // serial_flash_ctrl_test

`default_nettype wire
